// *** verilog/mdo_pkg.sv ***
// Notes on behaviour
// R1: Remote mode drives the output only from on and off commands.
// R2: Demand mode pulses the output at each close of the chosen demand interval.
// R3: Alarm mode pulses the output when any selected alarm becomes triggered.
// R4: Energy mode pulses the output from the chosen energy quantity at a set rate.
// R5: Normal behaviour, remote or alarm only, keeps output on until an off command.
// R6: Timed behaviour holds the output on for exactly the on-time, then turns off.
// R7: On-time is whole seconds 0 to 9999; larger values are rejected.
// R8: Latched behaviour turns on at energize and off at release.
// R9: Latched state is saved non-volatile and restored when power returns.
// R10: Latched behaviour is accepted only with remote or alarm control.
// R11: Software must pick latched behaviour for outputs tied to a unary alarm.
// R12: Demand mode offers power, current or input metering as the demand system.
// R13: Alarm mode lets one or more alarms be selected as trigger sources.
// R14: Timing uses a one-second tick; output is off after reset unless restored.
package mdo_pkg;

  // ==========================================================
  // Modes and selectors.
  typedef enum logic [1:0] {
    CTL_REMOTE = 2'h0,
    CTL_DEMAND = 2'h1,
    CTL_ALARM = 2'h2,
    CTL_ENERGY = 2'h3
  } mdo_ctl_t;

  typedef enum logic [1:0] {
    BEH_NORMAL = 2'h0,
    BEH_TIMED = 2'h1,
    BEH_LATCHED = 2'h2
  } mdo_beh_t;

  localparam logic [1:0] DMD_SEL_MAX = 2'h2;

  // ==========================================================
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ONTIME = 8'h04;
  localparam logic [7:0] OFS_ALARM = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_RATE = 8'h14;

  // ==========================================================
  // Field positions.
  localparam int CTRL_CTL_LSB = 0;
  localparam int CTRL_BEH_LSB = 2;
  localparam int CTRL_DMD_LSB = 4;
  localparam int CTRL_NRG_LSB = 8;
  localparam int CMD_ON_BIT = 0;
  localparam int CMD_OFF_BIT = 1;
  localparam int STAT_OUT_BIT = 0;
  localparam int STAT_REJ_BIT = 1;
  localparam int STAT_SECS_LSB = 16;

  // ==========================================================
  // Widths, limits and reset values.
  localparam int ONTIME_W = 14;
  localparam int ALARM_W = 16;
  localparam int NRG_W = 8;
  localparam int RATE_W = 24;
  localparam logic [13:0] ONTIME_MAX = 14'd9999;
  localparam logic [13:0] ONTIME_RST = 14'h0000;
  localparam logic [23:0] RATE_RST = 24'h000001;
  localparam logic [15:0] ALARM_RST = 16'h0000;

  // ==========================================================
  // Timing.
  localparam longint SEC_NS = 1000000000;
  localparam longint CLK_NS = 10;
  localparam int unsigned SEC_CYCLES = int'(SEC_NS / CLK_NS);

endpackage : mdo_pkg

// *** verilog/mdo_tick.sv ***
`timescale 1ns/1ps
// Restartable period counter that pulses once every CYCLES clocks.
module mdo_tick #(
  parameter int unsigned CYCLES = 100
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clr,
  output logic tick
);
  import mdo_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } mdo_tick_st_t;

  mdo_tick_st_t s_q;
  mdo_tick_st_t s_d;

  // A restart loads one so the first tick lands exactly CYCLES clocks later.
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (clr) begin
      s_d.cnt = 32'h00000001;
    end else if (s_q.cnt >= CYCLES - 1) begin
      s_d.cnt = 32'h00000000;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 32'h00000001;
    end
  end

  // State register.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule : mdo_tick

// *** verilog/mdo_ctrl.sv ***
// Implementation choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
// Digital output channel controller with an AHB-Lite register slave.
module mdo_ctrl #(
  parameter int unsigned TICK_CYCLES = mdo_pkg::SEC_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [2:0] demand_end,
  input wire logic [mdo_pkg::ALARM_W-1:0] alarm_trig,
  input wire logic [mdo_pkg::NRG_W-1:0] energy_inc,
  input wire logic nv_valid,
  input wire logic nv_state,
  output logic nv_wr_en,
  output logic nv_wr_state,
  output logic dout
);
  import mdo_pkg::*;

  // ==========================================================
  // State.
  // Configuration, the output itself, the energy accumulator and the bus
  // data-phase bookkeeping live in one record held by one bank of flops.
  typedef struct packed {
    logic boot;
    mdo_ctl_t ctl;
    mdo_beh_t beh;
    logic [1:0] dmd_sel;
    logic [2:0] nrg_sel;
    logic [ONTIME_W-1:0] on_time;
    logic [ALARM_W-1:0] alarm_sel;
    logic [RATE_W-1:0] rate;
    logic [RATE_W-1:0] nrg_cnt;
    logic [ALARM_W-1:0] alarm_prev;
    logic [ONTIME_W-1:0] secs;
    logic out;
    logic reject;
    logic wr_pend;
    logic [7:0] wr_ofs;
    logic [31:0] rdata;
    logic ready;
    logic resp;
    logic nv_wr_en;
    logic nv_wr_state;
  } mdo_st_t;

  mdo_st_t s_q;
  mdo_st_t s_d;
  logic tick;
  logic tick_clr;

  // One-second time base, restarted at the start of each timed pulse.
  mdo_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .mclk(mclk),
    .rst_n(rst_n),
    .clr(tick_clr),
    .tick(tick)
  );

  // ==========================================================
  // Next state.
  always_comb begin
    logic addr_ok;
    logic wr_now;
    logic cmd_on;
    logic cmd_off;
    logic trig;
    logic [1:0] n_ctl;
    logic [1:0] n_beh;
    logic [1:0] n_dmd;
    logic [RATE_W-1:0] lim;
    logic rej_set;
    logic rej_clr;
    s_d = s_q;
    addr_ok = hsel && htrans[1] && hready;
    wr_now = s_q.wr_pend;
    cmd_on = 1'b0;
    cmd_off = 1'b0;
    trig = 1'b0;
    n_ctl = hwdata[CTRL_CTL_LSB +: 2];
    n_beh = hwdata[CTRL_BEH_LSB +: 2];
    n_dmd = hwdata[CTRL_DMD_LSB +: 2];
    lim = (s_q.rate == '0) ? RATE_RST : s_q.rate;
    rej_set = 1'b0;
    rej_clr = 1'b0;
    tick_clr = 1'b0;
    s_d.boot = 1'b0;
    s_d.ready = 1'b1;
    s_d.resp = 1'b0;
    s_d.nv_wr_en = 1'b0;
    s_d.alarm_prev = alarm_trig;

    // Data phase of a write applies the captured address.
    if (wr_now) begin
      case (s_q.wr_ofs)
        OFS_CTRL: begin
          // Normal and latched only with remote or alarm; bad selectors refused.
          if ((n_beh > BEH_LATCHED) || (n_dmd > DMD_SEL_MAX) ||
              ((n_beh != BEH_TIMED) &&
               ((n_ctl == CTL_DEMAND) || (n_ctl == CTL_ENERGY)))) begin
            rej_set = 1'b1; // R10
          end else begin
            s_d.ctl = mdo_ctl_t'(n_ctl);
            s_d.beh = mdo_beh_t'(n_beh);
            s_d.dmd_sel = n_dmd; // R12
            s_d.nrg_sel = hwdata[CTRL_NRG_LSB +: 3]; // R4
          end
        end
        OFS_ONTIME: begin
          if (hwdata > 32'(ONTIME_MAX)) begin
            rej_set = 1'b1; // R7
          end else begin
            s_d.on_time = hwdata[ONTIME_W-1:0]; // R7
          end
        end
        OFS_ALARM: begin
          s_d.alarm_sel = hwdata[ALARM_W-1:0]; // R13
        end
        OFS_CMD: begin
          // Both bits act in the cycle the word arrives; off wins further down.
          cmd_on = hwdata[CMD_ON_BIT];
          cmd_off = hwdata[CMD_OFF_BIT];
        end
        OFS_STATUS: begin
          // Writing one to the reject bit clears it; the other bits are read only.
          rej_clr = hwdata[STAT_REJ_BIT];
        end
        OFS_RATE: begin
          s_d.rate = hwdata[RATE_W-1:0]; // R4
        end
        default: begin
          s_d.rate = s_q.rate;
        end
      endcase
    end

    // A new rejection wins over a clear in the same cycle.
    if (rej_set) begin
      s_d.reject = 1'b1;
    end else if (rej_clr) begin
      s_d.reject = 1'b0;
    end

    // Address phase: capture writes, prepare read data for the data phase.
    // Register reads see what a write in this same cycle leaves behind, so a read
    // issued right behind a write returns the new value; the status output and seconds bits come from s_q, one cycle behind.
    s_d.wr_pend = addr_ok && hwrite;
    s_d.wr_ofs = haddr[7:0];
    s_d.rdata = '0;
    if (addr_ok && !hwrite) begin
      case (haddr[7:0])
        OFS_CTRL: begin
          s_d.rdata[CTRL_CTL_LSB +: 2] = s_d.ctl;
          s_d.rdata[CTRL_BEH_LSB +: 2] = s_d.beh;
          s_d.rdata[CTRL_DMD_LSB +: 2] = s_d.dmd_sel;
          s_d.rdata[CTRL_NRG_LSB +: 3] = s_d.nrg_sel;
        end
        OFS_ONTIME: begin
          s_d.rdata[ONTIME_W-1:0] = s_d.on_time;
        end
        OFS_ALARM: begin
          s_d.rdata[ALARM_W-1:0] = s_d.alarm_sel;
        end
        OFS_STATUS: begin
          s_d.rdata[STAT_OUT_BIT] = s_q.out;
          s_d.rdata[STAT_REJ_BIT] = s_d.reject;
          s_d.rdata[STAT_SECS_LSB +: ONTIME_W] = s_q.secs;
        end
        OFS_RATE: begin
          s_d.rdata[RATE_W-1:0] = s_d.rate;
        end
        default: begin
          s_d.rdata = '0;
        end
      endcase
    end

    // Energy increments of the chosen quantity count up to the pulse rate.
    if ((s_q.ctl == CTL_ENERGY) && energy_inc[s_q.nrg_sel]) begin
      if (s_q.nrg_cnt + 24'h000001 >= lim) begin
        s_d.nrg_cnt = '0;
        trig = 1'b1; // R4
      end else begin
        s_d.nrg_cnt = s_q.nrg_cnt + 24'h000001;
      end
    end

    // Source selection by control mode.
    case (s_q.ctl)
      CTL_REMOTE: begin
        trig = cmd_on; // R1
      end
      CTL_DEMAND: begin
        // Only the three defined demand systems can fire the output.
        case (s_q.dmd_sel)
          2'h0: begin
            trig = demand_end[0]; // R2
          end
          2'h1: begin
            trig = demand_end[1]; // R2
          end
          2'h2: begin
            trig = demand_end[2]; // R2
          end
          default: begin
            trig = 1'b0;
          end
        endcase
      end
      CTL_ALARM: begin
        trig = cmd_on || (|(alarm_trig & ~s_q.alarm_prev & s_q.alarm_sel)); // R3
      end
      CTL_ENERGY: begin
        // The pulse counter above has already decided this cycle's trigger.
        trig = trig;
      end
      default: begin
        trig = 1'b0;
      end
    endcase

    // Timed pulse countdown on the one-second tick.
    if ((s_q.beh == BEH_TIMED) && s_q.out && tick) begin
      s_d.secs = s_q.secs - 14'h0001; // R14
      if (s_q.secs <= 14'h0001) begin
        s_d.out = 1'b0; // R6
        s_d.secs = '0;
      end
    end

    // Turn on: timed loads the on-time, others hold until released.
    if (trig) begin
      if (s_q.beh == BEH_TIMED) begin
        if (s_q.on_time != '0) begin
          s_d.out = 1'b1; // R6
          s_d.secs = s_q.on_time;
          tick_clr = 1'b1; // R14
        end
      end else begin
        s_d.out = 1'b1; // R5 R8
      end
    end

    // In remote or alarm control an off or release command ends any output state; off wins over on.
    if (cmd_off && ((s_q.ctl == CTL_REMOTE) || (s_q.ctl == CTL_ALARM))) begin
      s_d.out = 1'b0; // R5 R8
      s_d.secs = '0;
    end

    // First cycle after reset restores a saved latched state.
    if (s_q.boot) begin
      if (nv_valid) begin
        s_d.beh = BEH_LATCHED; // R9
        s_d.out = nv_state; // R9 R14
      end else begin
        s_d.out = 1'b0; // R14
      end
    end

    // Every change of a latched output, except the restore at boot, is written to the non-volatile store.
    if ((s_d.beh == BEH_LATCHED) && (s_d.out != s_q.out) && !s_q.boot) begin
      s_d.nv_wr_en = 1'b1; // R9
      s_d.nv_wr_state = s_d.out;
    end
  end

  // ==========================================================
  // State register.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.boot <= 1'b1;
      s_q.ctl <= CTL_REMOTE;
      s_q.beh <= BEH_NORMAL;
      s_q.on_time <= ONTIME_RST;
      s_q.alarm_sel <= ALARM_RST;
      s_q.rate <= RATE_RST;
      s_q.ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs, all straight from the state register.
  assign hrdata = s_q.rdata;
  assign hreadyout = s_q.ready;
  // The slave never errors, yet its response still leaves a flop.
  assign hresp = s_q.resp;
  assign nv_wr_en = s_q.nv_wr_en;
  assign nv_wr_state = s_q.nv_wr_state;
  assign dout = s_q.out;

endmodule : mdo_ctrl

// *** bench/mdo_ctrl_chk.sv ***
`timescale 1ns/1ps
// ==========================================================
// Port checker for the output channel.
module mdo_ctrl_chk #(
  parameter int unsigned TICK_CYCLES = 10
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [2:0] demand_end,
  input wire logic [15:0] alarm_trig,
  input wire logic [7:0] energy_inc,
  input wire logic nv_valid,
  input wire logic nv_state,
  input wire logic nv_wr_en,
  input wire logic nv_wr_state,
  input wire logic dout
);
  import mdo_pkg::*;
  logic rd_q, cmd_q, cause;
  logic [7:0] ad_q;
  logic [15:0] al_q;
  logic [2:0] hist_q, age_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // A rise may follow a command, a demand end, an alarm edge or an energy step.
  assign cause = (cmd_q & hwdata[0]) | (|demand_end) | (|(alarm_trig & ~al_q)) | (|energy_inc);
  // Track bus phases, alarm levels and the age since reset.
  always_ff @(posedge mclk) begin
    rd_q <= rst_n & hsel & htrans[1] & hready & ~hwrite;
    cmd_q <= rst_n & hsel & htrans[1] & hready & hwrite & (haddr[7:0] == OFS_CMD);
    ad_q <= haddr[7:0];
    al_q <= alarm_trig;
    hist_q <= {hist_q[1:0], cause};
    age_q <= !rst_n ? 3'h0 : ((age_q == 3'h7) ? age_q : age_q + 3'h1);
  end
  okay_resp_a: assert property (!hresp)
    else $error("response not okay");
  ready_high_a: assert property (hreadyout)
    else $error("wait state inserted");
  reset_off_a: assert property ($rose(rst_n) |-> !dout ##1 (dout == (nv_valid && nv_state)))
    else $error("output on after reset");
  restore_state_a: assert property ($rose(rst_n) |-> ##2 dout == (nv_valid & nv_state))
    else $error("retained state not restored");
  nv_store_a: assert property (nv_wr_en |-> nv_wr_state == dout && dout != $past(dout))
    else $error("stored state differs from output");
  idle_rdata_a: assert property (!rd_q |-> hrdata == 32'h0)
    else $error("read data without a read");
  ontime_range_a: assert property (rd_q && ad_q == OFS_ONTIME |-> hrdata <= 32'h270f)
    else $error("on-time out of range");
  rise_cause_a: assert property ($rose(dout) && age_q == 3'h7 |-> |hist_q)
    else $error("output rose without a trigger");
  cover property ($rose(dout));
  cover property (nv_wr_en);
  cover property (rd_q && ad_q == OFS_STATUS);
endmodule : mdo_ctrl_chk

bind mdo_ctrl mdo_ctrl_chk #(
  .TICK_CYCLES(TICK_CYCLES)
) u_chk (
  .mclk(mclk),
  .rst_n(rst_n),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .hready(hready),
  .hrdata(hrdata),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .demand_end(demand_end),
  .alarm_trig(alarm_trig),
  .energy_inc(energy_inc),
  .nv_valid(nv_valid),
  .nv_state(nv_state),
  .nv_wr_en(nv_wr_en),
  .nv_wr_state(nv_wr_state),
  .dout(dout)
);

// *** bench/mdo_load.sv ***
`timescale 1ns/1ps
// ==========================================================
// Far side: a relay load that counts closures, and the retained store.
module mdo_load (
  input wire logic mclk,
  input wire logic dout,
  input wire logic nv_wr_en,
  input wire logic nv_wr_state,
  input wire logic nv_clr,
  output logic nv_valid,
  output logic nv_state,
  output int n_pulse,
  output int width
);
  int run = 0;
  logic last = 1'b0;
  // Nothing is retained at power up.
  initial begin
    nv_valid = 1'b0;
    nv_state = 1'b0;
    n_pulse = 0;
    width = 0;
  end
  // The coil counts each closure and times how long it stays closed.
  always @(posedge mclk) begin
    last <= dout;
    run <= dout ? run + 1 : 0;
    if (dout && !last) begin
      n_pulse <= n_pulse + 1;
    end
    if (!dout && last) begin
      width <= run;
    end
  end
  // The store keeps the last state written, across resets of the controller.
  always @(posedge mclk) begin
    if (nv_clr) begin
      nv_valid <= 1'b0;
    end else if (nv_wr_en) begin
      nv_valid <= 1'b1;
      nv_state <= nv_wr_state;
    end
  end
endmodule : mdo_load

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); \
  end \
end
// ==========================================================
// Bench for the output channel controller.
module tb_top;
  import mdo_pkg::*;
  localparam int TK = 10;
  typedef struct packed {
    logic [7:0] wa;
    logic [31:0] wd;
    logic [7:0] ra;
    logic [31:0] msk;
    logic [31:0] ex;
  } mdo_row_t;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [2:0] demand_end = 3'h0;
  logic [15:0] alarm_trig = 16'h0;
  logic [7:0] energy_inc = 8'h0;
  logic nv_clr = 1'b0;
  wire logic hready;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, nv_valid, nv_state, nv_wr_en, nv_wr_state, dout;
  int n_pulse, width, np;
  int n_errors = 0;
  int n_compared = 0;
  mdo_row_t rows [12] = '{
    '{OFS_ONTIME, 32'h270f, OFS_ONTIME, 32'hffffffff, 32'h270f},
    '{OFS_ONTIME, 32'h2710, OFS_STATUS, 32'h2, 32'h2},
    '{OFS_STATUS, 32'h2, OFS_STATUS, 32'h2, 32'h0},
    '{OFS_CTRL, 32'hc, OFS_CTRL, 32'hffffffff, 32'h0},
    '{OFS_CTRL, 32'h9, OFS_CTRL, 32'hffffffff, 32'h0},
    '{OFS_CTRL, 32'h1, OFS_CTRL, 32'hffffffff, 32'h0},
    '{OFS_CTRL, 32'h35, OFS_CTRL, 32'hffffffff, 32'h0},
    '{OFS_CTRL, 32'hb, OFS_CTRL, 32'hffffffff, 32'h0},
    '{OFS_CTRL, 32'ha, OFS_CTRL, 32'hffffffff, 32'ha},
    '{OFS_ALARM, 32'h5, OFS_ALARM, 32'hffffffff, 32'h5},
    '{OFS_RATE, 32'h123456, OFS_RATE, 32'hffffffff, 32'h123456},
    '{8'h18, 32'h7, 8'h18, 32'hffffffff, 32'h0}
  };
  assign hready = hreadyout;
  // Design, far-side load and clock.
  mdo_ctrl #(
    .TICK_CYCLES(TK)
  ) u_dut (
    .mclk(mclk),
    .rst_n(rst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .demand_end(demand_end),
    .alarm_trig(alarm_trig),
    .energy_inc(energy_inc),
    .nv_valid(nv_valid),
    .nv_state(nv_state),
    .nv_wr_en(nv_wr_en),
    .nv_wr_state(nv_wr_state),
    .dout(dout)
  );
  mdo_load u_load (
    .mclk(mclk),
    .dout(dout),
    .nv_wr_en(nv_wr_en),
    .nv_wr_state(nv_wr_state),
    .nv_clr(nv_clr),
    .nv_valid(nv_valid),
    .nv_state(nv_state),
    .n_pulse(n_pulse),
    .width(width)
  );
  always #5 mclk = ~mclk;
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  // One single-word transfer: address phase, then data phase.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic reset;
    rst_n <= 1'b0;
    cyc(5);
    rst_n <= 1'b1;
    cyc(1);
  endtask : reset
  task automatic test_done;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  // Watchdog for a hung bus or output.
  initial begin
    #200000;
    n_errors++;
    test_done();
  end
  // Main sequence.
  initial begin
    reset();
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      xfer(1'b0, rows[i].ra, 32'h0);
      `CHK(rd & rows[i].msk, rows[i].ex)
    end
    $display("test registers done");
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CMD, 32'h1);
    cyc(30);
    `CHK(dout, 1'b1)
    wr(OFS_CMD, 32'h3);
    cyc(2);
    `CHK(dout, 1'b0)
    $display("test remote done");
    wr(OFS_ONTIME, 32'h2);
    wr(OFS_CTRL, 32'h4);
    wr(OFS_CMD, 32'h1);
    xfer(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd & 32'h3fff0001, 32'h00020001)
    cyc(3 * TK);
    `CHK(width, 2 * TK)
    wr(OFS_ONTIME, 32'h0);
    np = n_pulse;
    wr(OFS_CMD, 32'h1);
    cyc(5);
    `CHK(n_pulse, np)
    $display("test timed done");
    wr(OFS_ONTIME, 32'h1);
    for (int s = 0; s < 3; s++) begin
      wr(OFS_CTRL, 32'h5 | (32'(s) << 4));
      np = n_pulse;
      demand_end <= 3'h1 << ((s + 1) % 3);
      cyc(1);
      demand_end <= 3'h1 << s;
      cyc(1);
      demand_end <= 3'h0;
      cyc(2 * TK);
      `CHK(n_pulse, np + 1)
      `CHK(width, TK)
    end
    $display("test demand done");
    wr(OFS_CTRL, 32'h6);
    np = n_pulse;
    alarm_trig <= 16'h2;
    cyc(5);
    `CHK(n_pulse, np)
    alarm_trig <= 16'h6;
    cyc(2 * TK);
    `CHK(n_pulse, np + 1)
    alarm_trig <= 16'h0;
    $display("test alarm done");
    wr(OFS_RATE, 32'h2);
    wr(OFS_CTRL, 32'h207);
    np = n_pulse;
    energy_inc <= 8'h1;
    cyc(1);
    energy_inc <= 8'h4;
    cyc(1);
    energy_inc <= 8'h0;
    cyc(1);
    energy_inc <= 8'h4;
    cyc(1);
    energy_inc <= 8'h0;
    cyc(2 * TK);
    `CHK(n_pulse, np + 1)
    $display("test energy done");
    wr(OFS_CTRL, 32'h8);
    wr(OFS_CMD, 32'h1);
    cyc(3);
    `CHK(nv_state, 1'b1)
    reset();
    cyc(4);
    `CHK(dout, 1'b1)
    wr(OFS_CMD, 32'h2);
    cyc(2);
    `CHK(dout, 1'b0)
    nv_clr <= 1'b1;
    reset();
    cyc(4);
    `CHK(dout, 1'b0)
    $display("test latched done");
    test_done();
  end
endmodule : tb_top
